// *** common/dect_pkg.sv ***
/*
 * constants, register map and types for the dual edge capture unit.
 * assumes byte wide register access from a plain strobe port.
 */
`default_nettype none

package dect_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] capture_config_addr = 8'h2a;
    localparam logic [7:0] capture_irq_enable_addr = 8'h2b;
    localparam logic [7:0] capture_irq_status_addr = 8'h2c;
    localparam logic [7:0] cap_zero_rise_addr = 8'h22;
    localparam logic [7:0] cap_one_rise_addr = 8'h23;
    localparam logic [7:0] cap_zero_fall_addr = 8'h24;
    localparam logic [7:0] cap_one_fall_addr = 8'h25;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int hold_bit = 7;
    localparam int prescale_lsb = 4;
    localparam int wide_bit = 3;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [3:0] irq_reset = 4'h0;
    localparam logic [7:0] capture_reset = 8'h00;

    // capture register index: 0 zero rise, 1 zero fall, 2 one rise, 3 one fall
    localparam int num_cap = 4;

    typedef struct packed {
        logic hold;
        logic [2:0] prescale;
        logic wide;
    } dect_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dect_bus_t;

endpackage

`default_nettype wire

// *** src/dect_edge.sv ***
/*
 * synchroniser and edge detector for one capture input.
 * assumes the pin is already synchronous to clk, second stage adds margin.
 */
`timescale 1ns/1ps
`default_nettype none

module dect_edge (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);

    logic sync_a;
    logic sync_b;
    logic last;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            last <= sync_b;
        end
    end

    assign rise = sync_b & ~last; // R16
    assign fall = ~sync_b & last; // R16

endmodule

`default_nettype wire

// *** src/dect_slot.sv ***
/*
 * one capture register with first edge hold.
 * assumes load and read_hit are single cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module dect_slot (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hold,
    input wire logic load,
    input wire logic [7:0] value,
    input wire logic read_hit,
    output logic [7:0] data,
    output logic loaded
);

    logic full;
    wire take = load & ~(hold & full); // R5 R6

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data <= dect_pkg::capture_reset;
            full <= 1'b0;
        end else begin
            if (take) begin
                data <= value; // R14
            end
            if (take) begin
                full <= 1'b1;
            end else if (read_hit) begin
                full <= 1'b0; // R17
            end
        end
    end

    assign loaded = take;

endmodule

`default_nettype wire

// *** src/dect_top.sv ***
/*
 * dual edge capture unit: two 8 bit channels or one 16 bit capture.
 * assumes a free running 16 bit timer input and a byte register port.
 */
// How it works
// [R1] two 8 bit channels each keep a rising time and a falling time register.
// [R2] in 16 bit mode channel one registers hold the upper timer byte.
// [R3] each capture register raises an interrupt when loaded, if enabled; in 16 bit mode status bits 3 and 2 follow pin one edges instead.
// [R4] config bit 7 selects hold mode for all four capture registers.
// [R5] with hold off every edge overwrites the capture register.
// [R6] with hold on the first edge is kept until software reads the register.
// [R7] prescale bits 6 to 4 pick timer bits n+7 down to n in 8 bit mode.
// [R8] config bit 3 turns channel one into the upper byte of channel zero.
// [R9] enable bits 3 to 0 gate one fall, one rise, zero fall, zero rise.
// [R10] status bits 3 to 0 set on one fall, one rise, zero fall, zero rise.
// [R11] writing one clears a status bit; no new interrupt while it stays set.
// [R12] software clears each status bit after service.
// [R13] config bits 2 to 0 and the upper nibbles of enable and status are reserved.
// [R14] each capture register stores the timer at its own pin's edge; in 16 bit mode channel one registers load on pin zero edges.
// [R15] in 16 bit mode channel one holds the upper byte of channel zero's edge.
// [R16] inputs are synchronised and edges found from consecutive samples.
// [R17] in hold mode a read releases only the register that was read.
`timescale 1ns/1ps
`default_nettype none

module dect_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic capture_in_zero,
    input wire logic capture_in_one,
    input wire logic [15:0] timer,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq
);

    // ****************************************************************
    // registers
    // ****************************************************************
    dect_pkg::dect_cfg_t cfg;
    logic [3:0] capture_irq_enable;
    logic [3:0] capture_irq_status;
    logic [3:0] next_status;
    logic [7:0] next_rdata;

    dect_pkg::dect_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire hit_cfg = bus.addr == dect_pkg::capture_config_addr;
    wire hit_en = bus.addr == dect_pkg::capture_irq_enable_addr;
    wire hit_st = bus.addr == dect_pkg::capture_irq_status_addr;

    // ****************************************************************
    // edge detection
    // ****************************************************************
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;

    dect_edge u_edge0 (
        .clk(clk),
        .arst_n(arst_n),
        .pin(capture_in_zero),
        .rise(rise0),
        .fall(fall0)
    );

    dect_edge u_edge1 (
        .clk(clk),
        .arst_n(arst_n),
        .pin(capture_in_one),
        .rise(rise1),
        .fall(fall1)
    );

    // ****************************************************************
    // capture slots
    // ****************************************************************
    wire [15:0] shifted = timer >> cfg.prescale; // R7
    wire [7:0] slice = shifted[7:0]; // R7
    wire [7:0] low_val = cfg.wide ? timer[7:0] : slice;
    wire [7:0] one_val = cfg.wide ? timer[15:8] : slice; // R2 R15

    // index order: zero rise, zero fall, one rise, one fall
    wire [3:0] edges = {fall1, rise1, fall0, rise0};
    wire [3:0] loads;
    assign loads[0] = edges[0];
    assign loads[1] = edges[1];
    assign loads[2] = cfg.wide ? edges[0] : edges[2]; // R8
    assign loads[3] = cfg.wide ? edges[1] : edges[3]; // R8

    wire [7:0] cap_addr [dect_pkg::num_cap];
    assign cap_addr[0] = dect_pkg::cap_zero_rise_addr;
    assign cap_addr[1] = dect_pkg::cap_zero_fall_addr;
    assign cap_addr[2] = dect_pkg::cap_one_rise_addr;
    assign cap_addr[3] = dect_pkg::cap_one_fall_addr;

    logic [7:0] cap_data [dect_pkg::num_cap];
    logic [3:0] loaded;

    genvar gi;
    generate
        for (gi = 0; gi < dect_pkg::num_cap; gi++) begin : g_slot
            dect_slot u_slot (
                .clk(clk),
                .arst_n(arst_n),
                .hold(cfg.hold), // R4
                .load(loads[gi]), // R1
                .value(gi < 2 ? low_val : one_val),
                .read_hit(bus.rd && bus.addr == cap_addr[gi]), // R17
                .data(cap_data[gi]),
                .loaded(loaded[gi])
            );
        end
    endgenerate

    // status bit order: 3 one fall, 2 one rise, 1 zero fall, 0 zero rise
    // in wide mode channel one loads follow channel zero, status follows pins
    wire [3:0] status_set = {cfg.wide ? fall1 : loaded[3],
                             cfg.wide ? rise1 : loaded[2],
                             loaded[1], loaded[0]}; // R3 R10

    // set wins over a simultaneous clear
    always_comb begin
        next_status = capture_irq_status;
        if (bus.wr && hit_st) begin
            next_status = next_status & ~bus.wdata[3:0]; // R11
        end
        next_status = next_status | status_set; // R10
    end

    // ****************************************************************
    // register write and read
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= dect_pkg::config_reset[7:3];
            capture_irq_enable <= dect_pkg::irq_reset;
            capture_irq_status <= dect_pkg::irq_reset;
        end else begin
            if (bus.wr && hit_cfg) begin
                cfg <= bus.wdata[7:3]; // R4 R7 R8
            end
            if (bus.wr && hit_en) begin
                capture_irq_enable <= bus.wdata[3:0]; // R9
            end
            capture_irq_status <= next_status;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (hit_cfg) begin
            next_rdata = {cfg, 3'h0}; // R13
        end else if (hit_en) begin
            next_rdata = {4'h0, capture_irq_enable}; // R13
        end else if (hit_st) begin
            next_rdata = {4'h0, capture_irq_status}; // R13
        end else if (bus.addr == cap_addr[0]) begin
            next_rdata = cap_data[0];
        end else if (bus.addr == cap_addr[1]) begin
            next_rdata = cap_data[1];
        end else if (bus.addr == cap_addr[2]) begin
            next_rdata = cap_data[2];
        end else if (bus.addr == cap_addr[3]) begin
            next_rdata = cap_data[3];
        end
    end

    // level interrupt from a flip-flop; one cycle after the status bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            rdata <= bus.rd ? next_rdata : 8'h00;
            irq <= |(capture_irq_status & capture_irq_enable); // R3 R9 R11 R12
        end
    end

endmodule

`default_nettype wire

// *** tb/dect_top_props.sv ***
/*
 * port level assertions for the dual edge capture unit.
 * assumes it is bound to dect_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module dect_top_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic capture_in_zero,
    input wire logic capture_in_one,
    input wire logic [15:0] timer,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    // ****************************************************************
    // shadow of the writable control registers
    // ****************************************************************
    logic [7:0] cfg_sh;
    logic [3:0] en_sh;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_sh <= 8'h00;
            en_sh <= 4'h0;
        end else if (wr && addr == 8'h2a) begin
            cfg_sh <= wdata & 8'hf8;
        end else if (wr && addr == 8'h2b) begin
            en_sh <= wdata[3:0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    read_idle_zero_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    cfg_readback_a: assert property ($past(rd) && $past(addr) == 8'h2a |->
        rdata == $past(cfg_sh)) else $error("config read back wrong");
    en_readback_a: assert property ($past(rd) && $past(addr) == 8'h2b |->
        rdata == {4'h0, $past(en_sh)}) else $error("enable read back wrong");
    status_reserved_a: assert property ($past(rd) && $past(addr) == 8'h2c |->
        rdata[7:4] == 4'h0) else $error("status upper bits not zero");
    irq_gated_a: assert property (irq |-> $past(en_sh) != 4'h0)
        else $error("interrupt with all sources disabled");
    irq_fall_cause_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped without a write");
    rise_irq_a: assert property ($rose(capture_in_zero) && en_sh[0] && !cfg_sh[7]
        |-> ##[3:5] irq) else $error("no interrupt after rise on pin zero");
    fall_one_irq_a: assert property ($fell(capture_in_one) && en_sh[3] && !cfg_sh[7]
        |-> ##[3:5] irq) else $error("no interrupt after fall on pin one");

    cover property (irq ##1 !irq);
    cover property ($rose(capture_in_zero) && cfg_sh[7]);
    cover property (rd && addr == 8'h23 && cfg_sh[3]);
endmodule

`default_nettype wire

// *** tb/dect_pins.sv ***
/*
 * model of the two external capture signals.
 * assumes the bench calls drive and each level is held six cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module dect_pins (
    input wire logic clk,
    output logic pin_zero,
    output logic pin_one
);
    initial begin
        pin_zero = 1'b0;
        pin_one = 1'b0;
    end

    // level held long enough for synchroniser, capture and interrupt
    task automatic drive(input int ch, input logic v);
        @(posedge clk);
        if (ch == 0)
            pin_zero <= v;
        else
            pin_one <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// *** tb/dect_top_bench.sv ***
/*
 * self checking bench for the dual edge capture unit.
 * assumes dect_top, dect_pins and dect_top_props are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module dect_top_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] timer = 16'h0000;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq;
    wire logic pz;
    wire logic po;
    int miscompares = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    dect_pins i_pins (.clk(clk), .pin_zero(pz), .pin_one(po));
    dect_top i_dut (.clk(clk), .arst_n(arst_n), .capture_in_zero(pz), .capture_in_one(po),
        .timer(timer), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

    // ****************************************************************
    // bus, pin and compare tasks
    // ****************************************************************
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        #1;
        check(rdata, e);
    endtask

    task automatic pin(input int ch, input logic v, input logic [15:0] t);
        @(posedge clk);
        timer <= t;
        i_pins.drive(ch, v);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        #1;
        check({7'h00, irq}, {7'h00, e});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_basic;
        rd_chk(8'h2a, 8'h00);
        bus(1'b1, 8'h2a, 8'hff);
        rd_chk(8'h2a, 8'hf8);
        bus(1'b1, 8'h2a, 8'h00);
        rd_chk(8'h00, 8'h00);
        pin(0, 1'b1, 16'h0011);
        pin(0, 1'b0, 16'h0022);
        pin(0, 1'b1, 16'h0033);
        bus(1'b1, 8'h22, 8'haa);
        rd_chk(8'h22, 8'h33);
        rd_chk(8'h24, 8'h22);
        $display("basic done");
    endtask

    task automatic t_hold;
        bus(1'b1, 8'h2a, 8'h80);
        pin(0, 1'b0, 16'h0044);
        pin(0, 1'b1, 16'h0055);
        pin(0, 1'b0, 16'h0066);
        pin(0, 1'b1, 16'h0077);
        rd_chk(8'h24, 8'h44);
        pin(0, 1'b0, 16'h0088);
        pin(0, 1'b1, 16'h0099);
        rd_chk(8'h24, 8'h88);
        rd_chk(8'h22, 8'h55);
        bus(1'b1, 8'h2a, 8'h00);
        $display("hold done");
    endtask

    task automatic t_prescale;
        logic [15:0] r;
        logic [15:0] f;
        for (int n = 0; n < 8; n++) begin
            bus(1'b1, 8'h2a, {1'b0, 3'(n), 4'h0});
            pin(1, 1'b1, 16'h5a3c);
            pin(1, 1'b0, 16'hc3a5);
            r = 16'h5a3c >> n;
            f = 16'hc3a5 >> n;
            rd_chk(8'h23, r[7:0]);
            rd_chk(8'h25, f[7:0]);
        end
        $display("prescale done");
    endtask

    task automatic t_wide;
        bus(1'b1, 8'h2a, 8'h08);
        pin(0, 1'b0, 16'h1234);
        pin(0, 1'b1, 16'hbeef);
        pin(1, 1'b1, 16'h7777);
        pin(1, 1'b0, 16'h6666);
        rd_chk(8'h22, 8'hef);
        rd_chk(8'h23, 8'hbe);
        rd_chk(8'h24, 8'h34);
        rd_chk(8'h25, 8'h12);
        bus(1'b1, 8'h2a, 8'h00);
        $display("wide done");
    endtask

    task automatic t_irq;
        bus(1'b1, 8'h2c, 8'hff);
        rd_chk(8'h2c, 8'h00);
        bus(1'b1, 8'h2b, 8'hff);
        rd_chk(8'h2b, 8'h0f);
        irq_chk(1'b0);
        pin(1, 1'b1, 16'h0001);
        rd_chk(8'h2c, 8'h04);
        irq_chk(1'b1);
        pin(1, 1'b0, 16'h0002);
        bus(1'b1, 8'h2c, 8'h04);
        rd_chk(8'h2c, 8'h08);
        bus(1'b1, 8'h2b, 8'h07);
        irq_chk(1'b0);
        pin(0, 1'b0, 16'h0003);
        pin(0, 1'b1, 16'h0004);
        rd_chk(8'h2c, 8'h0b);
        bus(1'b1, 8'h2c, 8'h0f);
        irq_chk(1'b0);
        $display("irq done");
    endtask

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_basic();
        t_hold();
        t_prescale();
        t_wide();
        t_irq();
        close_out();
    end

    // whole run is well under 1500 cycles
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule

bind dect_top dect_top_props i_props (.clk(clk), .arst_n(arst_n),
    .capture_in_zero(capture_in_zero), .capture_in_one(capture_in_one), .timer(timer),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

`default_nettype wire
